// >>> hw/csel_pkg.sv
// Shared constants and types for the system clock selector
package csel_pkg;
  // Reference clock rate
  localparam int CLK_MHZ = 100;
  // Longest silence tolerated on the external oscillator before it is declared dead
  localparam int MON_TIMEOUT_NS = 1000;
  // Longest time rounds down to whole cycles
  localparam int MON_TIMEOUT_CYC = (MON_TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam int MON_CNT_W = 8;
  localparam logic [MON_CNT_W-1:0] MON_LIMIT = MON_CNT_W'(MON_TIMEOUT_CYC);
  // Real-time clock source: external oscillator divided by 128
  localparam int RTC_DIV = 128;
  localparam int RTC_CNT_W = 7;
  localparam logic [RTC_CNT_W-1:0] RTC_LAST = RTC_CNT_W'(RTC_DIV - 1);
  // Prescalers: divide code is log2 of the ratio
  localparam int DIV_W = 4;
  localparam int DIV_CNT_W = 16;
  localparam int NUM_BUS = 3;
  localparam int BUS_AHB = 0;
  localparam int BUS_APB2 = 1;
  localparam int BUS_APB1 = 2;
  // System clock sources
  typedef enum logic [1:0] {
    SRC_IRC = 2'b00,
    SRC_EXT = 2'b01,
    SRC_PLL = 2'b10
  } csel_src_t;
endpackage

// >>> hw/csel_div_if.sv
// Carrier between the selector and one bus prescaler
`timescale 1ns/1ps
`default_nettype none
interface csel_div_if;
  logic tick_in;
  logic [csel_pkg::DIV_W-1:0] div_log2;
  logic tick_out;
  modport presc (input tick_in, input div_log2, output tick_out);
  modport src (output tick_in, output div_log2, input tick_out);
endinterface
`default_nettype wire

// >>> hw/csel_presc.sv
// Power-of-two bus clock prescaler producing a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module csel_presc #(
  parameter int CNT_W = csel_pkg::DIV_CNT_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Tick in, divided tick out
  csel_div_if.presc bus
);

  logic [CNT_W-1:0] cnt_reg;
  logic tick_reg;

  // Mask of counter bits that must all be set for an output tick
  function automatic logic [CNT_W-1:0] mask_of(input logic [csel_pkg::DIV_W-1:0] d);
    mask_of = ~({CNT_W{1'b1}} << d);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Free-running count of input ticks
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else if (bus.tick_in) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Output tick on every 2^div input tick
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= bus.tick_in && ((cnt_reg & mask_of(bus.div_log2)) == mask_of(bus.div_log2));
    end
  end

  assign bus.tick_out = tick_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_div_tick;
    @(posedge ref_clk) disable iff (!rstn)
    (bus.tick_in && ((cnt_reg & mask_of(bus.div_log2)) == mask_of(bus.div_log2))) |=> bus.tick_out;
  endproperty
  a_div_tick: assert property (p_div_tick) else $error("prescaler missed its tick");

  property p_div_quiet;
    @(posedge ref_clk) disable iff (!rstn)
    (!bus.tick_in || (cnt_reg[0] == 1'b0 && bus.div_log2 != '0)) |=> !bus.tick_out;
  endproperty
  a_div_quiet: assert property (p_div_quiet) else $error("prescaler ticked out of turn");

endmodule
`default_nettype wire

// >>> hw/csel_top.sv
// System clock selector: source switch, external clock monitor, prescalers
`timescale 1ns/1ps
`default_nettype none
module csel_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Oscillator inputs
  input wire logic external_highspeed_osc,
  input wire logic internal_rc_osc_tick,
  input wire logic pll_tick,
  // Software controls
  input wire csel_pkg::csel_src_t src_req,
  input wire logic ext_osc_on,
  input wire logic pll_on,
  input wire logic css_irq_en,
  input wire logic pll_irq_en,
  input wire logic fail_clr,
  input wire logic stop_mode,
  // Prescaler codes, log2 of ratio
  input wire logic [csel_pkg::DIV_W-1:0] ahb_div,
  input wire logic [csel_pkg::DIV_W-1:0] apb2_div,
  input wire logic [csel_pkg::DIV_W-1:0] apb1_div,
  // Oscillator enables
  output logic internal_rc_osc_en,
  output logic ext_osc_en,
  output logic pll_en,
  // Selected source
  output csel_pkg::csel_src_t sys_src,
  // Clock ticks
  output logic ahb_tick,
  output logic apb2_tick,
  output logic apb1_tick,
  output logic flash_prog_if_clock,
  output logic usb_function_clock,
  output logic rtc_ext_div_tick,
  // Status and interrupts
  output logic css_fail_flag,
  output logic pll_fail_flag,
  output logic css_irq,
  output logic pll_irq
);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  csel_pkg::csel_src_t src_reg;
  csel_pkg::csel_src_t src_next;
  logic sync1_reg, sync2_reg, sync3_reg;
  logic ext_edge;
  logic [csel_pkg::MON_CNT_W-1:0] mon_cnt_reg;
  logic ext_ok, fail_evt, src_tick;
  logic css_flag_reg, pll_flag_reg, css_irq_reg, pll_irq_reg;
  logic irc_en_reg, ext_en_reg, pll_en_reg;
  logic flash_reg, usb_reg, rtc_reg;
  logic [csel_pkg::RTC_CNT_W-1:0] rtc_cnt_reg;
  logic [csel_pkg::DIV_W-1:0] div_code [csel_pkg::NUM_BUS];
  logic seen_reg;

  ////////////////////////////////////////////////////////////////////////////
  // External oscillator pin: two flops, then a third for edge detection
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= external_highspeed_osc;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign ext_edge = sync2_reg && !sync3_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Silence counter; parked at the limit so a stopped oscillator is never trusted
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mon_cnt_reg <= csel_pkg::MON_LIMIT;
    end else if (!ext_osc_on || stop_mode) begin
      mon_cnt_reg <= csel_pkg::MON_LIMIT;
    end else if (ext_edge) begin
      mon_cnt_reg <= '0;
    end else if (mon_cnt_reg != csel_pkg::MON_LIMIT) begin
      mon_cnt_reg <= mon_cnt_reg + 1'b1;
    end
  end

  assign ext_ok = (mon_cnt_reg != csel_pkg::MON_LIMIT);
  // Failure only counts while the external path feeds the system clock
  assign fail_evt = (src_reg != csel_pkg::SRC_IRC) && ext_osc_on && !stop_mode && !ext_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Source choice: requested source only while its oscillator is alive and no failure is pending
  always_comb begin
    src_next = csel_pkg::SRC_IRC;
    if (fail_evt) begin
      src_next = csel_pkg::SRC_IRC;
    end else if (src_req == csel_pkg::SRC_EXT && ext_osc_on && ext_ok && !css_flag_reg) begin
      src_next = csel_pkg::SRC_EXT;
    end else if (src_req == csel_pkg::SRC_PLL && pll_on && ext_osc_on && ext_ok && !css_flag_reg) begin
      src_next = csel_pkg::SRC_PLL;
    end
  end

  // Selected source register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      src_reg <= csel_pkg::SRC_IRC;
    end else begin
      src_reg <= src_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky failure flags; a new failure wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      css_flag_reg <= 1'b0;
      pll_flag_reg <= 1'b0;
    end else begin
      if (fail_evt) begin
        css_flag_reg <= 1'b1;
      end else if (fail_clr) begin
        css_flag_reg <= 1'b0;
      end
      if (fail_evt && pll_on) begin
        pll_flag_reg <= 1'b1;
      end else if (fail_clr) begin
        pll_flag_reg <= 1'b0;
      end
    end
  end

  // Interrupt lines, gated by their enables
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      css_irq_reg <= 1'b0;
      pll_irq_reg <= 1'b0;
    end else begin
      css_irq_reg <= css_flag_reg && css_irq_en;
      pll_irq_reg <= pll_flag_reg && pll_irq_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator enables drop in stop mode
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irc_en_reg <= 1'b1;
      ext_en_reg <= 1'b0;
      pll_en_reg <= 1'b0;
    end else begin
      irc_en_reg <= !stop_mode;
      ext_en_reg <= ext_osc_on && !stop_mode;
      pll_en_reg <= pll_on && !stop_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source tick mux feeding the AHB prescaler
  always_comb begin
    case (src_reg)
      csel_pkg::SRC_EXT: src_tick = ext_edge;
      csel_pkg::SRC_PLL: src_tick = pll_tick;
      default: src_tick = internal_rc_osc_tick;
    endcase
    if (stop_mode) begin
      src_tick = 1'b0;
    end
  end

  assign div_code[csel_pkg::BUS_AHB] = ahb_div;
  assign div_code[csel_pkg::BUS_APB2] = apb2_div;
  assign div_code[csel_pkg::BUS_APB1] = apb1_div;

  // AHB divides the source; both APB buses divide the AHB tick
  csel_div_if div_if [csel_pkg::NUM_BUS] ();
  for (genvar g = 0; g < csel_pkg::NUM_BUS; g++) begin : g_bus
    if (g == csel_pkg::BUS_AHB) begin : g_src
      assign div_if[g].tick_in = src_tick;
    end else begin : g_ahb
      assign div_if[g].tick_in = div_if[csel_pkg::BUS_AHB].tick_out;
    end
    assign div_if[g].div_log2 = div_code[g];
    csel_presc u_presc (
      .ref_clk (ref_clk),
      .rstn (rstn),
      .bus (div_if[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fixed clock paths: flash always on internal RC, USB only from PLL fed by external
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flash_reg <= 1'b0;
      usb_reg <= 1'b0;
    end else begin
      flash_reg <= internal_rc_osc_tick && !stop_mode;
      usb_reg <= pll_tick && pll_on && ext_osc_on && !stop_mode;
    end
  end

  // RTC option: external oscillator edges divided down
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rtc_cnt_reg <= '0;
      rtc_reg <= 1'b0;
    end else begin
      rtc_reg <= 1'b0;
      if (ext_edge && ext_osc_on && !stop_mode) begin
        rtc_cnt_reg <= rtc_cnt_reg + 1'b1;
        rtc_reg <= (rtc_cnt_reg == csel_pkg::RTC_LAST);
      end
    end
  end

  // Marks the first cycle after reset release, for checking only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= 1'b1;
    end
  end

  assign sys_src = src_reg;
  assign internal_rc_osc_en = irc_en_reg;
  assign ext_osc_en = ext_en_reg;
  assign pll_en = pll_en_reg;
  assign ahb_tick = div_if[csel_pkg::BUS_AHB].tick_out;
  assign apb2_tick = div_if[csel_pkg::BUS_APB2].tick_out;
  assign apb1_tick = div_if[csel_pkg::BUS_APB1].tick_out;
  assign flash_prog_if_clock = flash_reg;
  assign usb_function_clock = usb_reg;
  assign rtc_ext_div_tick = rtc_reg;
  assign css_fail_flag = css_flag_reg;
  assign pll_fail_flag = pll_flag_reg;
  assign css_irq = css_irq_reg;
  assign pll_irq = pll_irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_reset_src;
    !seen_reg |-> sys_src == csel_pkg::SRC_IRC;
  endproperty
  a_reset_src: assert property (p_reset_src) else $error("reset did not pick internal RC");

  property p_monitor;
    (sys_src != csel_pkg::SRC_IRC && ext_osc_on && !stop_mode && !ext_edge)[*8] |->
      mon_cnt_reg >= 8'h07;
  endproperty
  a_monitor: assert property (p_monitor) else $error("silence counter not running");

  property p_fallback;
    fail_evt |=> sys_src == csel_pkg::SRC_IRC && css_fail_flag;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no fallback after clock failure");

  property p_css_irq;
    (css_fail_flag && css_irq_en) |=> css_irq;
  endproperty
  a_css_irq: assert property (p_css_irq) else $error("enabled failure interrupt missing");

  property p_css_mask;
    !css_irq_en |=> !css_irq;
  endproperty
  a_css_mask: assert property (p_css_mask) else $error("masked failure interrupt raised");

  property p_pll_fail;
    (fail_evt && pll_on && pll_irq_en) |=> pll_fail_flag ##1 pll_irq;
  endproperty
  a_pll_fail: assert property (p_pll_fail) else $error("PLL path failure not signalled");

  property p_flash_clk;
    (internal_rc_osc_tick && !stop_mode) |=> flash_prog_if_clock;
  endproperty
  a_flash_clk: assert property (p_flash_clk) else $error("flash clock not on internal RC");

  property p_stop;
    stop_mode [*3] |=> !ahb_tick && !apb1_tick && !apb2_tick && !internal_rc_osc_en && !ext_osc_en && !pll_en;
  endproperty
  a_stop: assert property (p_stop) else $error("clocks alive in stop mode");

  property p_rtc_div;
    (ext_edge && ext_osc_on && !stop_mode && rtc_cnt_reg == csel_pkg::RTC_LAST) |=>
      rtc_ext_div_tick && rtc_cnt_reg == '0;
  endproperty
  a_rtc_div: assert property (p_rtc_div) else $error("RTC divider wrong");

  property p_sticky;
    (css_fail_flag && !fail_clr) |=> css_fail_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("failure flag lost");

endmodule
`default_nettype wire

// >>> test/csel_xtal_model.sv
// Behavioural external crystal for the clock selector
`timescale 1ns/1ps
`default_nettype none
module csel_xtal_model #(
  parameter realtime HALF_NS = 35.25
) (
  // Control from the device and the bench
  input wire logic en,
  input wire logic dead,
  // Oscillator waveform
  output logic osc
);
  ////////////////////////////////////////////////////////////////////////////
  // About 14.2 MHz; odd start phase keeps edges off the sampling clock edge
  initial begin
    osc = 1'b0;
    #0.3;
    forever begin
      #HALF_NS;
      // A stopped or failed crystal stands still at zero
      if (en && !dead) begin
        osc = ~osc;
      end else begin
        osc = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/system_clock_selector_test.sv
// Self-checking bench for the system clock selector
`timescale 1ns/1ps
`default_nettype none
module system_clock_selector_test;
  logic ref_clk = 1'b0, rstn = 1'b0, xtal, rc_tick = 1'b0, pll_tick = 1'b0, dead = 1'b0;
  csel_pkg::csel_src_t src_req = csel_pkg::SRC_IRC, sys_src;
  logic ext_osc_on = 1'b0, pll_on = 1'b0, css_irq_en = 1'b0, pll_irq_en = 1'b0;
  logic fail_clr = 1'b0, stop_mode = 1'b0;
  logic [csel_pkg::DIV_W-1:0] ahb_div = 4'h0, apb2_div = 4'h0, apb1_div = 4'h0;
  logic irc_en, ext_en, pll_en, ahb_t, apb2_t, apb1_t, flash_t, usb_t, rtc_t;
  logic css_flag, pll_flag, css_irq, pll_irq;
  int err_total = 0, checks_done = 0, cyc_cnt = 0, rc_period = 3, rc_cnt = 0, xtal_edges = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and far side
  always #5 ref_clk = ~ref_clk;
  always @(posedge xtal) xtal_edges++;
  // Internal RC and PLL ticks, driven on the falling edge
  always @(negedge ref_clk) begin
    rc_tick <= (rc_cnt == 0);
    rc_cnt <= (rc_cnt + 1 >= rc_period) ? 0 : rc_cnt + 1;
    pll_tick <= ~pll_tick;
  end
  csel_xtal_model xtal_m (.en(ext_en), .dead(dead), .osc(xtal));

  csel_top dut (
    .ref_clk(ref_clk), .rstn(rstn), .external_highspeed_osc(xtal), .internal_rc_osc_tick(rc_tick),
    .pll_tick(pll_tick), .src_req(src_req), .ext_osc_on(ext_osc_on), .pll_on(pll_on),
    .css_irq_en(css_irq_en), .pll_irq_en(pll_irq_en), .fail_clr(fail_clr), .stop_mode(stop_mode),
    .ahb_div(ahb_div), .apb2_div(apb2_div), .apb1_div(apb1_div), .internal_rc_osc_en(irc_en),
    .ext_osc_en(ext_en), .pll_en(pll_en), .sys_src(sys_src), .ahb_tick(ahb_t), .apb2_tick(apb2_t),
    .apb1_tick(apb1_t), .flash_prog_if_clock(flash_t), .usb_function_clock(usb_t),
    .rtc_ext_div_tick(rtc_t), .css_fail_flag(css_flag), .pll_fail_flag(pll_flag), .css_irq(css_irq),
    .pll_irq(pll_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic end_sim;
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Start the crystal, let the monitor see it, then ask for a source
  task automatic go_src(input csel_pkg::csel_src_t src);
    ext_osc_on = 1'b1;
    cyc(15);
    src_req = src;
    cyc(2);
    check("sys_src after request", sys_src, src);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    check("sys_src at reset", sys_src, csel_pkg::SRC_IRC);
    check("irc enable at reset", irc_en, 1'b1);
    src_req = csel_pkg::SRC_EXT;
    cyc(3);
    check("external refused while off", sys_src, csel_pkg::SRC_IRC);
    src_req = csel_pkg::SRC_IRC;
    cyc(1);
  endtask

  // Fail the crystal under a given source with interrupts on or off
  task automatic t_fail(input csel_pkg::csel_src_t src, input logic irq_on);
    int n;
    n = 0;
    css_irq_en = irq_on;
    pll_irq_en = irq_on;
    pll_on = (src == csel_pkg::SRC_PLL);
    go_src(src);
    check("osc enables on", {ext_en, pll_en}, {1'b1, src == csel_pkg::SRC_PLL});
    // USB path only runs with both external oscillator and PLL on
    repeat (20) begin
      cyc(1);
      n += usb_t;
    end
    check("usb pulses", n, (src == csel_pkg::SRC_PLL) ? 10 : 0);
    n = 0;
    dead = 1'b1;
    while (sys_src !== csel_pkg::SRC_IRC && n < 150) begin
      cyc(1);
      n++;
    end
    check("fallback source", sys_src, csel_pkg::SRC_IRC);
    check("silence before fallback", (n >= csel_pkg::MON_TIMEOUT_CYC - 8 && n <= csel_pkg::MON_TIMEOUT_CYC + 8), 1);
    check("css flag", css_flag, 1'b1);
    check("pll flag", pll_flag, src == csel_pkg::SRC_PLL);
    cyc(1);
    check("css irq", css_irq, irq_on);
    check("pll irq", pll_irq, irq_on && src == csel_pkg::SRC_PLL);
    dead = 1'b0;
    cyc(15);
    check("flag held", css_flag, 1'b1);
    check("source held on internal", sys_src, csel_pkg::SRC_IRC);
    fail_clr = 1'b1;
    cyc(1);
    fail_clr = 1'b0;
    cyc(2);
    check("css flag cleared", css_flag, 1'b0);
    check("css irq cleared", css_irq, 1'b0);
    src_req = csel_pkg::SRC_IRC;
    pll_on = 1'b0;
    cyc(2);
  endtask

  // Flash interface clock stays on the internal RC under the external source
  task automatic t_flash;
    int n;
    n = 0;
    go_src(csel_pkg::SRC_EXT);
    repeat (30) begin
      cyc(1);
      n += flash_t;
    end
    check("flash pulses", n, 30 / rc_period);
    src_req = csel_pkg::SRC_IRC;
    cyc(2);
  endtask

  // Ratios 2, 4 and 2*8 on a source ticking every cycle; all stay slow enough
  task automatic t_presc;
    int a, b, c;
    a = 0;
    b = 0;
    c = 0;
    rc_period = 1;
    ahb_div = 4'h1;
    apb2_div = 4'h1;
    apb1_div = 4'h3;
    cyc(40);
    repeat (64) begin
      cyc(1);
      a += ahb_t;
      b += apb2_t;
      c += apb1_t;
    end
    check("ahb ticks", a, 32);
    check("apb2 ticks", b, 16);
    check("apb1 ticks", c, 4);
  endtask

  task automatic t_stop;
    int n;
    n = 0;
    // Oscillators asked on, so the enables can only drop because of stop
    ext_osc_on = 1'b1;
    pll_on = 1'b1;
    stop_mode = 1'b1;
    cyc(1);
    check("osc enables in stop", {irc_en, ext_en, pll_en}, 3'h0);
    cyc(2);
    repeat (20) begin
      cyc(1);
      n += ahb_t + flash_t + apb1_t + apb2_t + usb_t + rtc_t;
    end
    check("ticks in stop", n, 0);
    stop_mode = 1'b0;
    pll_on = 1'b0;
    rc_period = 3;
    ahb_div = 4'h0;
    apb2_div = 4'h0;
    apb1_div = 4'h0;
    cyc(2);
  endtask

  task automatic t_rtc;
    int n, e0;
    n = 0;
    ext_osc_on = 1'b1;
    while (rtc_t !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    e0 = xtal_edges;
    cyc(1);
    while (rtc_t !== 1'b1 && n < 4000) begin
      cyc(1);
      n++;
    end
    check("edges per rtc tick", xtal_edges - e0, csel_pkg::RTC_DIV);
  endtask

  // Second reset while on the external source
  task automatic t_rereset;
    go_src(csel_pkg::SRC_EXT);
    rstn = 1'b0;
    cyc(1);
    check("sys_src in reset", sys_src, csel_pkg::SRC_IRC);
    check("irc enable in reset", irc_en, 1'b1);
    src_req = csel_pkg::SRC_IRC;
    rstn = 1'b1;
    cyc(2);
    check("sys_src after reset", sys_src, csel_pkg::SRC_IRC);
    check("css flag after reset", css_flag, 1'b0);
    check("ext enable after reset", ext_en, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Timeout and main sequence
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    cyc(1);
    t_reset();
    t_presc();
    t_stop();
    t_flash();
    t_fail(csel_pkg::SRC_EXT, 1'b1);
    t_fail(csel_pkg::SRC_EXT, 1'b0);
    t_fail(csel_pkg::SRC_PLL, 1'b1);
    t_rtc();
    t_rereset();
    end_sim();
  end
endmodule
`default_nettype wire
